//--- hdl/epic_defines.vh
// register offsets, field positions, reset values and timing counts of the pin interrupt block
`ifndef EPIC_DEFINES_VH
`define EPIC_DEFINES_VH

// register byte offsets
`define EPIC_OFS_MAIN_CONTROL   8'h00
`define EPIC_OFS_STATUS         8'h04
`define EPIC_OFS_NMI_CFG        8'h08
`define EPIC_OFS_IRQ_FLAGS      8'h0C
`define EPIC_OFS_NMI_FLAG       8'h10
`define EPIC_OFS_IRQ_MASK       8'h14
`define EPIC_OFS_ASYNC_SEL      8'h18
`define EPIC_OFS_SENSE_CFG      8'h1C

// main_control fields
`define EPIC_MC_ENABLE          0
`define EPIC_MC_CKSRC           1
// status fields
`define EPIC_ST_SYNC_PENDING    0
`define EPIC_ST_ACTIVE          1
// per-pin sense field: 3 bits of kind and one filter bit, 4 bits per pin
`define EPIC_CFG_W              4
`define EPIC_CFG_FILT           3

// sense kinds
`define EPIC_SENSE_NONE         3'h0
`define EPIC_SENSE_RISE         3'h1
`define EPIC_SENSE_FALL         3'h2
`define EPIC_SENSE_BOTH         3'h3
`define EPIC_SENSE_HIGH         3'h4
`define EPIC_SENSE_LOW          3'h5

// reset values
`define EPIC_RST_WORD           32'h0000_0000

// timing
`define EPIC_CLK_HZ             40000000
`define EPIC_LP_HZ              32768
`define EPIC_LP_DIV             (`EPIC_CLK_HZ / `EPIC_LP_HZ)
`define EPIC_GEN_DIV            4
`define EPIC_SYNC_CYC           2
`define EPIC_START_TICKS        3

`endif

//--- hdl/epic_pin_sense.v
// one input pin: synchroniser, glitch filter, edge and level sensing, standby lock
`default_nettype none

module epic_pin_sense (
  input  wire       clk,
  input  wire       rst,
  input  wire       pin_raw,
  input  wire       tick,
  input  wire       async_sel,
  input  wire [2:0] sense,
  input  wire       filt_on,
  input  wire       restart,
  input  wire       standby,
  output wire       hit
);
`include "epic_defines.vh"

  reg       meta_ff;
  reg       sync_ff;
  reg [2:0] hist_ff;
  reg       prev_ff;
  reg       lock_ff;

  wire       smp;
  wire [2:0] nxt_hist;
  wire       filt_new;
  reg        cond;

  // async path samples every clock, clocked path only on the selected tick
  assign smp      = async_sel | tick;
  assign nxt_hist = {hist_ff[1:0], sync_ff};
  // majority of three samples rejects single-sample glitches
  assign filt_new = filt_on ? ((nxt_hist[0] & nxt_hist[1]) | (nxt_hist[1] & nxt_hist[2]) |
                               (nxt_hist[0] & nxt_hist[2])) : nxt_hist[0];

  // two-flop synchroniser; the first stage feeds only the second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= pin_raw;
      sync_ff <= meta_ff;
    end
  end

  // history restarts at zero, so a high pin looks like a rising edge at start
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_ff <= 3'h0;
      prev_ff <= 1'b0;
    end else if (restart) begin
      hist_ff <= 3'h0;
      prev_ff <= 1'b0;
    end else if (smp) begin
      hist_ff <= nxt_hist;
      prev_ff <= filt_new;
    end
  end

  always @* begin
    case (sense)
      `EPIC_SENSE_RISE: cond = filt_new & ~prev_ff;
      `EPIC_SENSE_FALL: cond = ~filt_new & prev_ff;
      `EPIC_SENSE_BOTH: cond = filt_new ^ prev_ff;
      `EPIC_SENSE_HIGH: cond = filt_new;
      `EPIC_SENSE_LOW:  cond = ~filt_new;
      default:          cond = 1'b0;
    endcase
  end

  assign hit = smp & ~restart & cond & ~lock_ff;

  // in standby the async path keeps only the first edge until wake-up
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_ff <= 1'b0;
    end else if (!standby) begin
      lock_ff <= 1'b0;
    end else if (async_sel & hit) begin
      lock_ff <= 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- hdl/epic_ext_irq_ctrl.v
// external pin interrupt controller: registers, clock selection, start-up, flags, nmi
//
// Chosen here: strobed register access and the register offsets.
`default_nettype none
`include "epic_defines.vh"

module epic_ext_irq_ctrl #(
  parameter NPINS   = 8,
  parameter GEN_DIV = `EPIC_GEN_DIV,
  parameter LP_DIV  = `EPIC_LP_DIV
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [7:0]       addr,
  input  wire [31:0]      wdata,
  input  wire             wr_stb,
  input  wire             rd_stb,
  output reg  [31:0]      rdata,
  input  wire [NPINS-1:0] pin_in,
  input  wire             nmi_pin,
  input  wire             nmi_pullup,
  input  wire             wp_active,
  input  wire             standby,
  output reg              irq,
  output reg              nmi_req
);

  // timing counts at the width of the counters that load them
  localparam [1:0] SYNC_CYC    = `EPIC_SYNC_CYC;
  localparam [1:0] START_TICKS = `EPIC_START_TICKS;

  // control and configuration
  reg                   enable_ff;
  reg                   cksrc_ff;
  reg [NPINS-1:0]       async_ff;
  reg [NPINS*4-1:0]     cfg_ff;
  reg [3:0]             nmi_cfg_ff;
  reg [NPINS-1:0]       mask_ff;
  // state
  reg [NPINS-1:0]       flags_ff;
  reg                   nmi_flag_ff;
  reg [1:0]             sync_cnt_ff;
  reg [1:0]             start_cnt_ff;
  reg [10:0]            lp_cnt_ff;
  reg [7:0]             gen_cnt_ff;
  reg                   lp_tick_ff;
  reg                   gen_tick_ff;
  reg                   pull_meta_ff;
  reg                   pull_ff;

  wire                  wr_main;
  wire                  wr_nmi_cfg;
  wire                  wr_guard;
  wire                  tick;
  wire                  active;
  wire                  sync_pending;
  wire [NPINS-1:0]      pin_hit;
  wire                  nmi_hit;
  wire                  nmi_cfg_edge;
  wire                  nmi_immediate;
  wire [NPINS-1:0]      nxt_flags;
  wire                  nxt_nmi_flag;
  reg  [31:0]           cfg_word;

  // sense configuration zero-extended to a full word for read-back
  always @* begin
    cfg_word                = 32'h0000_0000;
    cfg_word[NPINS*4-1:0]   = cfg_ff;
  end

  // protected registers ignore writes while write protection is on
  assign wr_guard   = wr_stb & ~wp_active;
  assign wr_main    = wr_guard & (addr == `EPIC_OFS_MAIN_CONTROL);
  assign wr_nmi_cfg = wr_guard & (addr == `EPIC_OFS_NMI_CFG);

  // control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_ff  <= 1'b0;
      cksrc_ff   <= 1'b0;
      cfg_ff     <= {NPINS*4{1'b0}};
      nmi_cfg_ff <= 4'h0;
      mask_ff    <= {NPINS{1'b0}};
    end else if (wr_guard) begin
      case (addr)
        `EPIC_OFS_MAIN_CONTROL: begin
          enable_ff <= wdata[`EPIC_MC_ENABLE];
          cksrc_ff  <= wdata[`EPIC_MC_CKSRC];
        end
        `EPIC_OFS_SENSE_CFG: cfg_ff <= wdata[NPINS*4-1:0];
        `EPIC_OFS_NMI_CFG:   nmi_cfg_ff <= wdata[3:0];
        `EPIC_OFS_IRQ_MASK:  mask_ff <= wdata[NPINS-1:0];
        default: begin
        end
      endcase
    end
  end

  // async select escapes write protection: only the plain strobe gates it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      async_ff <= {NPINS{1'b0}};
    end else if (wr_stb && addr == `EPIC_OFS_ASYNC_SEL) begin
      async_ff <= wdata[NPINS-1:0];
    end
  end

  // pull-up state comes from the pin controller, resynchronised here
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pull_meta_ff <= 1'b0;
      pull_ff      <= 1'b0;
    end else begin
      pull_meta_ff <= nmi_pullup;
      pull_ff      <= pull_meta_ff;
    end
  end

  // generic and low-power clock rates as enable pulses
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_cnt_ff  <= 8'h00;
      gen_tick_ff <= 1'b0;
      lp_cnt_ff   <= 11'h000;
      lp_tick_ff  <= 1'b0;
    end else begin
      gen_tick_ff <= (gen_cnt_ff == GEN_DIV[7:0] - 8'h01);
      gen_cnt_ff  <= (gen_cnt_ff == GEN_DIV[7:0] - 8'h01) ? 8'h00 : gen_cnt_ff + 8'h01;
      lp_tick_ff  <= (lp_cnt_ff == LP_DIV[10:0] - 11'h001);
      lp_cnt_ff   <= (lp_cnt_ff == LP_DIV[10:0] - 11'h001) ? 11'h000 : lp_cnt_ff + 11'h001;
    end
  end

  assign tick = cksrc_ff ? lp_tick_ff : gen_tick_ff;

  // busy clears on the main clock after a short sync, not when sensing runs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_cnt_ff <= 2'h0;
    end else if (wr_main) begin
      sync_cnt_ff <= SYNC_CYC;
    end else if (sync_cnt_ff != 2'h0) begin
      sync_cnt_ff <= sync_cnt_ff - 2'h1;
    end
  end

  assign sync_pending = (sync_cnt_ff != 2'h0);

  // sensing waits for three ticks of the selected clock after enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      start_cnt_ff <= 2'h0;
    end else if (!enable_ff) begin
      start_cnt_ff <= 2'h0;
    end else if (tick && start_cnt_ff != START_TICKS) begin
      start_cnt_ff <= start_cnt_ff + 2'h1;
    end
  end

  assign active = enable_ff & (start_cnt_ff == START_TICKS);

  // one sensing unit per pin
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
      epic_pin_sense u_sense (
        .clk       (clk),
        .rst       (rst),
        .pin_raw   (pin_in[gi]),
        .tick      (tick),
        .async_sel (async_ff[gi]),
        .sense     (cfg_ff[gi*4 +: 3]),
        .filt_on   (cfg_ff[gi*4 + `EPIC_CFG_FILT]),
        .restart   (~active),
        .standby   (standby),
        .hit       (pin_hit[gi])
      );
    end
  endgenerate

  // a write that changes the sense kind restarts the nmi history, which can fake an edge
  assign nmi_cfg_edge = wr_nmi_cfg & (wdata[2:0] != nmi_cfg_ff[2:0]);

  epic_pin_sense u_nmi (
    .clk       (clk),
    .rst       (rst),
    .pin_raw   (nmi_pin),
    .tick      (tick),
    .async_sel (1'b0),
    .sense     (nmi_cfg_ff[2:0]),
    .filt_on   (nmi_cfg_ff[`EPIC_CFG_FILT]),
    .restart   (~active | nmi_cfg_edge),
    .standby   (1'b0),
    .hit       (nmi_hit)
  );

  // pulled-up pin looks like a rise the moment rise or both sense is written
  assign nmi_immediate = wr_nmi_cfg & pull_ff &
                         ((wdata[2:0] == `EPIC_SENSE_RISE) |
                          (wdata[2:0] == `EPIC_SENSE_BOTH));

  // sticky flags: a set in the clearing cycle wins over the clear
  assign nxt_flags = (flags_ff & ~((wr_stb && addr == `EPIC_OFS_IRQ_FLAGS) ?
                                   wdata[NPINS-1:0] : {NPINS{1'b0}})) | pin_hit;
  assign nxt_nmi_flag = (nmi_flag_ff & ~(wr_stb && addr == `EPIC_OFS_NMI_FLAG &&
                                         wdata[0])) | nmi_hit | nmi_immediate;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff    <= {NPINS{1'b0}};
      nmi_flag_ff <= 1'b0;
    end else begin
      flags_ff    <= nxt_flags;
      nmi_flag_ff <= nxt_nmi_flag;
    end
  end

  // outputs from flops, following the next flag values to save a cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq     <= 1'b0;
      nmi_req <= 1'b0;
    end else begin
      irq     <= |(nxt_flags & mask_ff);
      nmi_req <= nxt_nmi_flag;
    end
  end

  // read data in the cycle after the strobe, zero otherwise and for holes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= `EPIC_RST_WORD;
    end else if (rd_stb) begin
      case (addr)
        `EPIC_OFS_MAIN_CONTROL: rdata <= {30'h0000_0000, cksrc_ff, enable_ff};
        `EPIC_OFS_STATUS:       rdata <= {30'h0000_0000, active, sync_pending};
        `EPIC_OFS_NMI_CFG:      rdata <= {28'h000_0000, nmi_cfg_ff};
        `EPIC_OFS_IRQ_FLAGS:    rdata <= {{(32-NPINS){1'b0}}, flags_ff};
        `EPIC_OFS_NMI_FLAG:     rdata <= {31'h0000_0000, nmi_flag_ff};
        `EPIC_OFS_IRQ_MASK:     rdata <= {{(32-NPINS){1'b0}}, mask_ff};
        `EPIC_OFS_ASYNC_SEL:    rdata <= {{(32-NPINS){1'b0}}, async_ff};
        `EPIC_OFS_SENSE_CFG:    rdata <= cfg_word;
        default:                rdata <= `EPIC_RST_WORD;
      endcase
    end else begin
      rdata <= `EPIC_RST_WORD;
    end
  end

endmodule

`default_nettype wire

//--- sim/epic_ext_irq_ctrl_asserts.sv
// port-level checks of the pin interrupt controller
`default_nettype none
module epic_ext_irq_ctrl_asserts #(
  parameter NPINS = 8
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  input wire logic        nmi_pullup,
  input wire logic        wp_active,
  input wire logic        irq,
  input wire logic        nmi_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // bus cycles as seen at the ports; writes counted only when unprotected
  sequence s_wr(a); wr_stb && addr == a && !wp_active; endsequence
  sequence s_rd(a); rd_stb && addr == a; endsequence
  // pull-up must stay on long enough to pass the synchroniser
  sequence s_pu; nmi_pullup [*4]; endsequence
  property p_rd_idle; !rd_stb |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_unmap; rd_stb && (addr > 8'h1C || addr[1:0] != 2'h0) |=> rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_st_hi; s_rd(8'h04) |=> rdata[31:2] == 30'h0; endproperty
  a_st_hi: assert property (p_st_hi) else $error("status upper bits set");
  property p_sync; s_wr(8'h00) ##1 s_rd(8'h04) |=> rdata[0]; endproperty
  a_sync: assert property (p_sync) else $error("no pending after enable");
  property p_nmi; s_pu ##0 s_wr(8'h08) ##0 (wdata[1:0] == 2'h1 || wdata[1:0] == 2'h3)
    ##0 !wdata[2] |-> ##[1:2] nmi_req; endproperty
  a_nmi: assert property (p_nmi) else $error("no nmi on pulled-up write");
  property p_mask_off; s_wr(8'h14) ##0 wdata[NPINS-1:0] == '0 ##1 !wr_stb |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");
  property p_async_wp; wr_stb && wp_active && addr == 8'h18 ##1 s_rd(8'h18)
    |=> rdata[NPINS-1:0] == $past(wdata[NPINS-1:0], 2); endproperty
  a_async_wp: assert property (p_async_wp) else $error("path select blocked");
  property p_mask_rb; s_wr(8'h14) ##1 s_rd(8'h14)
    |=> rdata[NPINS-1:0] == $past(wdata[NPINS-1:0], 2); endproperty
  a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
endmodule

bind epic_ext_irq_ctrl epic_ext_irq_ctrl_asserts #(.NPINS(NPINS)) u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .nmi_pullup(nmi_pullup),
  .wp_active(wp_active), .irq(irq), .nmi_req(nmi_req));
`default_nettype wire

//--- sim/epic_pin_model.sv
// external sources behind the interrupt pins
`default_nettype none
module epic_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] lvl,
  input  wire logic       nlvl,
  input  wire logic       pu,
  output logic      [7:0] pin_in,
  output logic            nmi_pin,
  output logic            nmi_pullup
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {pin_in, nmi_pin, nmi_pullup} = 10'h000;
  // pins move part way into a cycle, out of step with the sampling clock
  always @(posedge clk) {pin_in, nmi_pin, nmi_pullup} <= #7 {lvl, nlvl, pu};
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench of the pin interrupt controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GDIV = 4;
  localparam int LDIV = 8;
  logic        clk, rst, wr_stb, rd_stb, wp_active, standby, irq, nmi_req;
  logic        nlvl, pu, nmi_pin, nmi_pullup, as, v0, v1, e, f;
  logic [2:0]  k;
  logic [7:0]  addr, lvl, pin_in;
  logic [31:0] wdata, rdata, d, r;
  int          miscompares, n_checks, p;
  int          cyc = 0;
  epic_ext_irq_ctrl #(.NPINS(8), .GEN_DIV(GDIV), .LP_DIV(LDIV)) dut (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .pin_in(pin_in), .nmi_pin(nmi_pin), .nmi_pullup(nmi_pullup), .wp_active(wp_active),
    .standby(standby), .irq(irq), .nmi_req(nmi_req));
  epic_pin_model pins (.clk(clk), .lvl(lvl), .nlvl(nlvl), .pu(pu), .pin_in(pin_in),
    .nmi_pin(nmi_pin), .nmi_pullup(nmi_pullup));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task results;
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobes stay up between back-to-back cycles; idle drops them
  task idle(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] x);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
    chk(d, x);
  endtask
  function logic hit(input logic [2:0] s, input logic a, input logic b);
    case (s)
      3'h1: return !a && b;
      3'h2: return a && !b;
      3'h3: return a != b;
      3'h4: return a || b;
      3'h5: return !a || !b;
      default: return 1'b0;
    endcase
  endfunction
  // read without a compare; the caller checks the fields it can predict
  task rd(input logic [7:0] a);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
  // enable, then poll status until sensing runs; ticks fix the window
  task su(input logic [31:0] m, input int lo, input int hi);
    int n;
    wr(8'h00, m);
    rc(8'h04, 32'h1);
    rc(8'h04, 32'h1);
    for (n = 3; d[1] !== 1'b1 && n < 200; n++) begin
      rd(8'h04);
      chk({31'h0, d[0]}, 32'h0);
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
    rc(8'h00, m);
  endtask
  initial begin
    {rst, wr_stb, rd_stb, wp_active, standby, nlvl, pu} = 7'h40;
    {addr, lvl, wdata, miscompares, n_checks} = '0;
    void'($urandom(85));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    for (int a = 0; a <= 32; a += 4) rc(a[7:0], 32'h0);
    r = $urandom;
    wr(8'h14, 32'h5A);
    rc(8'h14, 32'h5A);
    wp_active <= 1'b1;
    wr(8'h14, r);
    rc(8'h14, 32'h5A);
    wr(8'h18, r);
    rc(8'h18, r & 32'hFF);
    wp_active <= 1'b0;
    su(32'h1, 2 * GDIV, 4 * GDIV + 4);
    wr(8'h00, 32'h0);
    idle(4);
    rc(8'h04, 32'h0);
    su(32'h3, 2 * LDIV, 4 * LDIV + 4);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    idle(30);
    // sense kinds rise, fall, both, high and low on random pins, paths and levels
    for (int i = 0; i < 15; i++) begin
      p = $urandom % 8;
      k = 3'(1 + i % 5);
      {as, v0, v1, f} = 4'($urandom);
      wr(8'h18, 32'(as) << p);
      wr(8'h1C, 32'({f, k}) << (4 * p));
      wr(8'h14, 32'h1 << p);
      lvl[p] <= v0;
      idle(30);
      wr(8'h0C, 32'hFF);
      idle(30);
      lvl[p] <= v1;
      idle(30);
      e = hit(k, v0, v1);
      chk({31'h0, irq}, {31'h0, e});
      wr(8'h0C, 32'h0);
      rc(8'h0C, 32'(e) << p);
    end
    // standby on the asynchronous path keeps the first edge only
    wr(8'h18, 32'h8);
    wr(8'h1C, 32'h3000);
    wr(8'h14, 32'h0);
    lvl[3] <= 1'b0;
    idle(30);
    standby <= 1'b1;
    wr(8'h0C, 32'hFF);
    lvl[3] <= 1'b1;
    idle(10);
    rc(8'h0C, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr(8'h0C, 32'h8);
    lvl[3] <= 1'b0;
    idle(10);
    rc(8'h0C, 32'h0);
    standby <= 1'b0;
    idle(2);
    lvl[3] <= 1'b1;
    idle(10);
    rc(8'h0C, 32'h8);
    // pulled-up nonmaskable pin set to rising sense
    {pu, nlvl} <= 2'h3;
    idle(8);
    wr(8'h10, 32'h1);
    wr(8'h08, 32'h1);
    idle(2);
    chk({31'h0, nmi_req}, 32'h1);
    // the restarted history gives a false rise on the next tick; let it pass first
    idle(8);
    rc(8'h10, 32'h1);
    wr(8'h10, 32'h1);
    idle(3);
    chk({31'h0, nmi_req}, 32'h0);
    results;
  end
  // hang guard well above the roughly 1700 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results;
    end
  end
endmodule
`default_nettype wire
